// File: core/rct_clear_trigger.v
`timescale 1ns/1ps
`include "rct_defs.vh"
module rct_clear_trigger (
	input  wire       clk,
	input  wire       rst,
	input  wire       cmd_valid,
	input  wire [6:0] cmd_code,
	input  wire       listen_addressed,
	input  wire       irq_deselect,
	input  wire       dac_release,
	input  wire       trigger_out_clear,
	output reg        clear_active,
	output reg        trigger_out_status,
	output wire       hold
);
	reg  uni_clear;
	reg  hold_trigger_out;
	wire is_uni  = cmd_valid && (cmd_code == `RCT_CMD_UNIV_CLEAR);
	wire is_sel  = cmd_valid && (cmd_code == `RCT_CMD_SEL_CLEAR);
	wire is_trigger_out = cmd_valid && (cmd_code == `RCT_CMD_GROUP_TRIGGER_OUT);

	always @(posedge clk) begin
		if (rst) begin
			clear_active <= 1'b0;
			uni_clear    <= 1'b0;
			trigger_out_status  <= 1'b0;
			hold_trigger_out    <= 1'b0;
		end else begin
			if (is_uni) begin
				clear_active <= 1'b1;
				uni_clear    <= 1'b1;
			end else if (is_sel && listen_addressed) begin
				clear_active <= 1'b1;
				uni_clear    <= 1'b0;
			end else if (uni_clear ? !is_uni : !(is_sel && listen_addressed)) begin
				clear_active <= 1'b0;
				uni_clear    <= 1'b0;
			end
			if (is_trigger_out && listen_addressed && !irq_deselect) begin
				trigger_out_status <= 1'b1;
				hold_trigger_out   <= 1'b1;
			end else begin
				if (trigger_out_clear)
					trigger_out_status <= 1'b0;
				if (dac_release)
					hold_trigger_out <= 1'b0;
			end
		end
	end

	// handshake hold while clear is active or trigger unreleased
	assign hold = clear_active || hold_trigger_out;
endmodule // rct_clear_trigger

// File: core/rct_defs.vh
`ifndef RCT_DEFS_VH
`define RCT_DEFS_VH

// register addresses on the host port
`define RCT_ADDR_INT_STATUS   3'h0
`define RCT_ADDR_CMD_STATUS   3'h1
`define RCT_ADDR_ADDR_MODE    3'h2
`define RCT_ADDR_AUX_CMD      3'h3

// interrupt_status fields
`define RCT_INT_TRIGGER_OUT_BIT      5
`define RCT_INT_CMD_SUM_BIT   2

// command_status fields
`define RCT_CS_REMOTE_BIT     6
`define RCT_CS_LOCKOUT_BIT    5
`define RCT_CS_CHANGE_BIT     3
`define RCT_CS_CLEAR_BIT      1

// address_mode fields
`define RCT_AM_IRQ_DESEL_BIT  7

// auxiliary_command fields
`define RCT_AUX_DAC_REL_BIT   4
`define RCT_AUX_RTL_BIT       2
`define RCT_AUX_FORCE_BIT     0

// bus command codes, top bit ignored
`define RCT_CMD_UNIV_CLEAR    7'h14
`define RCT_CMD_SEL_CLEAR     7'h04
`define RCT_CMD_GROUP_TRIGGER_OUT    7'h08
`define RCT_CMD_GO_LOCAL      7'h01
`define RCT_CMD_LOCKOUT       7'h11

// reset values
`define RCT_RST_BYTE          8'h00

`endif

// File: core/rct_remote_local.v
`timescale 1ns/1ps
module rct_remote_local (
	input  wire       clk,
	input  wire       rst,
	input  wire       ren,
	input  wire       listen_addr_rx,
	input  wire       listen_active,
	input  wire       go_local_rx,
	input  wire       lockout_rx,
	input  wire       rtl_write,
	output reg        remote_flag,
	output reg        lockout_flag
);
	reg next_remote;
	reg next_lockout;

	always @* begin
		next_remote  = remote_flag;
		next_lockout = lockout_flag;
		if (!ren) begin
			next_remote  = 1'b0;
			next_lockout = 1'b0;
		end else begin
			if (listen_addr_rx)
				next_remote = 1'b1;
			if (lockout_rx) begin
				if (remote_flag || listen_addr_rx)
					next_lockout = 1'b1;
				else if (!listen_active)
					next_lockout = 1'b1;
			end
			if (go_local_rx)
				next_remote = 1'b0;
			else if (rtl_write && !lockout_flag)
				next_remote = 1'b0;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			remote_flag  <= 1'b0;
			lockout_flag <= 1'b0;
		end else begin
			remote_flag  <= next_remote;
			lockout_flag <= next_lockout;
		end
	end
endmodule // rct_remote_local

// File: core/rct_top.v
`timescale 1ns/1ps
`include "rct_defs.vh"
module rct_top (
	input  wire       CLOCK,
	input  wire       SYS_RST,
	input  wire [2:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	input  wire       REN,
	input  wire       CMD_VALID,
	input  wire [7:0] CMD_CODE,
	input  wire       LISTEN_ADDR_RX,
	input  wire       LISTEN_ADDRESSED,
	output wire       DAC_HOLD,
	output wire       TRIGGER_OUT
);
	localparam [7:0] RST_RDATA = `RCT_RST_BYTE;

	// host port decode
	wire       sel_int_status;
	wire       sel_cmd_status;
	wire       sel_addr_mode;
	wire       sel_aux_cmd;
	wire       wr_addr_mode;
	wire       wr_aux;
	wire       rd_cs;
	wire       rd_is;
	wire       rtl_write;
	// bus command decode
	wire [6:0] cmd_low;
	wire       go_local;
	wire       lockout;
	wire       trigger_out_take;
	// status from the submodules, plus cmd_summary and remote_toggle formed here
	wire       remote_flag;
	wire       lockout_flag;
	wire       clear_active;
	wire       trigger_out_status;
	wire       clear_hold;
	wire       cmd_summary;
	wire       remote_toggle;
	// host-written controls
	reg        irq_deselect;
	reg        force_trigger;
	reg        dac_release;
	reg        next_irq_deselect;
	reg        next_force_trigger;
	reg        next_dac_release;
	// change flag and trigger gate
	reg        remote_change_flag;
	reg        next_remote_change_flag;
	reg        prev_remote;
	reg        trigger_out_gate;
	reg        next_trigger_out_gate;
	// register images and read path
	reg  [7:0] int_status_image;
	reg  [7:0] cmd_status_image;
	reg  [7:0] addr_mode_image;
	reg  [7:0] aux_cmd_image;
	reg  [7:0] next_rdata;

	// host port address decode
	assign sel_int_status = (ADDR == `RCT_ADDR_INT_STATUS);
	assign sel_cmd_status = (ADDR == `RCT_ADDR_CMD_STATUS);
	assign sel_addr_mode  = (ADDR == `RCT_ADDR_ADDR_MODE);
	assign sel_aux_cmd    = (ADDR == `RCT_ADDR_AUX_CMD);
	assign wr_addr_mode   = WR && sel_addr_mode;
	assign wr_aux         = WR && sel_aux_cmd;
	assign rd_is          = RD && sel_int_status;
	assign rd_cs          = RD && sel_cmd_status;
	assign rtl_write      = wr_aux && WDATA[`RCT_AUX_RTL_BIT];

	// bus command decode, top bit of the byte ignored
	assign cmd_low   = CMD_CODE[6:0];
	assign go_local  = CMD_VALID && (cmd_low == `RCT_CMD_GO_LOCAL) && LISTEN_ADDRESSED;
	assign lockout   = CMD_VALID && (cmd_low == `RCT_CMD_LOCKOUT);
	assign trigger_out_take = CMD_VALID && (cmd_low == `RCT_CMD_GROUP_TRIGGER_OUT) && LISTEN_ADDRESSED
		&& !irq_deselect;

	rct_remote_local u_rl (
		.clk           (CLOCK),
		.rst           (SYS_RST),
		.ren           (REN),
		.listen_addr_rx(LISTEN_ADDR_RX),
		.listen_active (LISTEN_ADDRESSED),
		.go_local_rx   (go_local),
		.lockout_rx    (lockout),
		.rtl_write     (rtl_write),
		.remote_flag   (remote_flag),
		.lockout_flag  (lockout_flag)
	);

	rct_clear_trigger u_ct (
		.clk             (CLOCK),
		.rst             (SYS_RST),
		.cmd_valid       (CMD_VALID),
		.cmd_code        (CMD_CODE[6:0]),
		.listen_addressed(LISTEN_ADDRESSED),
		.irq_deselect    (irq_deselect),
		.dac_release     (dac_release),
		.trigger_out_clear      (rd_is),
		.clear_active    (clear_active),
		.trigger_out_status     (trigger_out_status),
		.hold            (clear_hold)
	);

	// summary: change flag always, clear active unless deselected
	assign cmd_summary   = remote_change_flag || (clear_active && !irq_deselect);
	assign remote_toggle = (remote_flag != prev_remote);
	assign DAC_HOLD      = clear_hold;
	assign TRIGGER_OUT   = (trigger_out_status && trigger_out_gate) || force_trigger;

	// host-written controls
	always @* begin
		next_irq_deselect  = irq_deselect;
		next_force_trigger = force_trigger;
		next_dac_release   = 1'b0;
		if (wr_addr_mode) begin
			next_irq_deselect = WDATA[`RCT_AM_IRQ_DESEL_BIT];
		end
		if (wr_aux) begin
			next_force_trigger = WDATA[`RCT_AUX_FORCE_BIT];
			next_dac_release   = WDATA[`RCT_AUX_DAC_REL_BIT];
		end
	end

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			irq_deselect  <= 1'b0;
			force_trigger <= 1'b0;
			dac_release   <= 1'b0;
		end else begin
			irq_deselect  <= next_irq_deselect;
			force_trigger <= next_force_trigger;
			dac_release   <= next_dac_release;
		end
	end

	// change flag: set wins over the read clear
	always @* begin
		next_remote_change_flag = remote_change_flag;
		if (remote_toggle) begin
			next_remote_change_flag = 1'b1;
		end else if (rd_cs) begin
			next_remote_change_flag = 1'b0;
		end
	end

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			prev_remote        <= 1'b0;
			remote_change_flag <= 1'b0;
		end else begin
			prev_remote        <= remote_flag;
			remote_change_flag <= next_remote_change_flag;
		end
	end

	// trigger pin gate, reopened by every accepted trigger
	always @* begin
		next_trigger_out_gate = trigger_out_gate;
		if (trigger_out_take) begin
			next_trigger_out_gate = 1'b1;
		end else if (!trigger_out_status) begin
			next_trigger_out_gate = 1'b1;
		end else if (dac_release) begin
			next_trigger_out_gate = 1'b0;
		end
	end

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			trigger_out_gate <= 1'b0;
		end else begin
			trigger_out_gate <= next_trigger_out_gate;
		end
	end

	// register images
	always @* begin
		int_status_image = 8'h00;
		int_status_image[`RCT_INT_TRIGGER_OUT_BIT]    = trigger_out_status;
		int_status_image[`RCT_INT_CMD_SUM_BIT] = cmd_summary;
	end

	always @* begin
		cmd_status_image = 8'h00;
		cmd_status_image[`RCT_CS_REMOTE_BIT]  = remote_flag;
		cmd_status_image[`RCT_CS_LOCKOUT_BIT] = lockout_flag;
		cmd_status_image[`RCT_CS_CHANGE_BIT]  = remote_change_flag;
		cmd_status_image[`RCT_CS_CLEAR_BIT]   = clear_active;
	end

	always @* begin
		addr_mode_image = 8'h00;
		addr_mode_image[`RCT_AM_IRQ_DESEL_BIT] = irq_deselect;
	end

	always @* begin
		aux_cmd_image = 8'h00;
		aux_cmd_image[`RCT_AUX_DAC_REL_BIT] = dac_release;
		aux_cmd_image[`RCT_AUX_FORCE_BIT]   = force_trigger;
	end

	// read mux, unmapped addresses read zero
	always @* begin
		next_rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				`RCT_ADDR_INT_STATUS: begin
					next_rdata = int_status_image;
				end
				`RCT_ADDR_CMD_STATUS: begin
					next_rdata = cmd_status_image;
				end
				`RCT_ADDR_ADDR_MODE: begin
					next_rdata = addr_mode_image;
				end
				`RCT_ADDR_AUX_CMD: begin
					next_rdata = aux_cmd_image;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	// read data register, one flip-flop per bit
	genvar bit_idx;
	generate
		for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_rdata
			always @(posedge CLOCK) begin
				if (SYS_RST) begin
					RDATA[bit_idx] <= RST_RDATA[bit_idx];
				end else begin
					RDATA[bit_idx] <= next_rdata[bit_idx];
				end
			end
		end
	endgenerate
endmodule // rct_top

// File: testbench/rct_chk_monitor.sv
`timescale 1ns/1ps
module rct_chk_monitor (
	input wire       CLOCK,
	input wire       SYS_RST,
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR,
	input wire       RD,
	input wire [7:0] RDATA,
	input wire       REN,
	input wire       CMD_VALID,
	input wire [7:0] CMD_CODE,
	input wire       LISTEN_ADDR_RX,
	input wire       LISTEN_ADDRESSED,
	input wire       DAC_HOLD,
	input wire       TRIGGER_OUT
);
	reg  desel;
	reg  frc;
	wire cmd_uc = CMD_VALID && CMD_CODE[6:0] == 7'h14;
	wire trigger_out_ok = CMD_VALID && CMD_CODE[6:0] == 7'h08 && LISTEN_ADDRESSED && !desel;
	wire rd_cs = RD && ADDR == 3'h1;
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			desel <= 1'b0;
			frc <= 1'b0;
		end else if (WR && ADDR == 3'h2) begin
			desel <= WDATA[7];
		end else if (WR && ADDR == 3'h3) begin
			frc <= WDATA[0];
		end
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	a_reset_quiet: assert property ($fell(SYS_RST) |-> RDATA == 8'h00 && !DAC_HOLD && !TRIGGER_OUT)
		else $error("outputs busy after reset");
	a_uclear_hold: assert property (cmd_uc && !WR |=> DAC_HOLD)
		else $error("clear left handshake free");
	a_trigger_out_set: assert property (trigger_out_ok && !WR |=> TRIGGER_OUT && DAC_HOLD)
		else $error("trigger not taken");
	a_trigger_out_cause: assert property ($rose(TRIGGER_OUT) |-> frc || $past(trigger_out_ok))
		else $error("trigger pin rose without cause");
	a_force_high: assert property (frc |-> TRIGGER_OUT)
		else $error("forced trigger pin low");
	a_dac_frees: assert property (WR && ADDR == 3'h3 && WDATA[4] && !WDATA[0] && !frc && !CMD_VALID
		##1 (!CMD_VALID && !WR) [*2] |-> !TRIGGER_OUT)
		else $error("release left trigger pin high");
	a_change_clear: assert property (!REN [*4] ##0 rd_cs ##1 rd_cs |=> !RDATA[3])
		else $error("change flag survived read");
	a_clear_bit: assert property (cmd_uc [*2] ##0 rd_cs |=> RDATA[1])
		else $error("clear bit missing");
	c_trigger_out: cover property (trigger_out_ok);
	c_clear: cover property (cmd_uc ##1 rd_cs);
	c_force: cover property (frc && TRIGGER_OUT);
endmodule // rct_chk_monitor

// File: testbench/rct_ctl_model.sv
`timescale 1ns/1ps
module rct_ctl_model (
	input wire       clk,
	output reg       ren,
	output reg       cmd_valid,
	output reg [7:0] cmd_code,
	output reg       laddr_rx,
	output reg       laddressed
);
	initial begin
		ren = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 8'hA5;
		laddr_rx = 1'b0;
		laddressed = 1'b0;
	end
	task lines(input r, input l);
		begin
			ren <= r;
			laddressed <= l;
		end
	endtask
	task cmd(input v, input [7:0] c);
		begin
			cmd_valid <= v;
			cmd_code <= v ? c : ~cmd_code;
		end
	endtask
	task rx;
		begin
			if (ren) laddr_rx <= 1'b1;
			@(posedge clk);
			laddr_rx <= 1'b0;
		end
	endtask
endmodule // rct_ctl_model

// File: testbench/test_remote_clear_trigger_functions.sv
`timescale 1ns/1ps
module test_remote_clear_trigger_functions;
	reg         clock, sys_rst, wr, rd, rd_d, r;
	reg  [2:0]  addr;
	reg  [7:0]  wdata;
	reg  [15:0] e;
	reg  [15:0] exp_q[$];
	wire [7:0]  rdata, cmd_code;
	wire        ren, cmd_valid, laddr_rx, laddressed, dac_hold, trigger_out;
	integer     mismatches, check_count, cyc, i;
	rct_top u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .REN(ren), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
		.LISTEN_ADDR_RX(laddr_rx), .LISTEN_ADDRESSED(laddressed), .DAC_HOLD(dac_hold),
		.TRIGGER_OUT(trigger_out));
	rct_ctl_model u_c (.clk(clock), .ren(ren), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.laddr_rx(laddr_rx), .laddressed(laddressed));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task test_done;
		begin
			$display("checks %0d mismatches %0d", check_count, mismatches);
			if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [7:0] g, input [7:0] x);
		begin
			check_count = check_count + 1;
			if (g !== x) begin
				mismatches = mismatches + 1;
				$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
			end
		end
	endtask
	task bus(input w, input q, input [2:0] a, input [7:0] d);
		begin
			@(posedge clock);
			wr <= w;
			rd <= q;
			addr <= a;
			wdata <= d;
		end
	endtask
	task idle(input integer n);
		repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
	endtask
	task rdx(input [2:0] a, input [7:0] x, input [7:0] m);
		begin
			exp_q.push_back({m, x});
			bus(1'b0, 1'b1, a, 8'h00);
		end
	endtask
	task pin(input [1:0] x);
		begin
			#1;
			chk({6'h00, trigger_out, dac_hold}, {6'h00, x});
		end
	endtask
	task pulse(input [6:0] c);
		begin
			u_c.cmd(1'b1, {r, c});
			idle(1);
			u_c.cmd(1'b0, 8'h00);
		end
	endtask
	always @(posedge clock) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			chk(rdata & e[15:8], e[7:0]);
		end
		rd_d <= rd;
		cyc = cyc + 1;
		if (cyc == 3000) begin
			mismatches = mismatches + 1;
			test_done;
		end
	end
	initial begin
		{sys_rst, wr, rd, rd_d, addr, wdata} = {4'h8, 11'h000};
		{mismatches, check_count, cyc} = 0;
		r = $urandom(28);
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		for (i = 0; i < 8; i = i + 1) rdx(i[2:0], 8'h00, 8'hFF);
		u_c.lines(1'b1, 1'b0);
		idle(1);
		u_c.rx;
		rdx(3'h1, 8'h48, 8'hFF);
		rdx(3'h1, 8'h40, 8'hFF);
		pulse(7'h11);
		rdx(3'h1, 8'h60, 8'hFF);
		bus(1'b1, 1'b0, 3'h3, 8'h04);
		idle(2);
		rdx(3'h1, 8'h60, 8'hFF);
		u_c.lines(1'b1, 1'b1);
		pulse(7'h01);
		rdx(3'h1, 8'h28, 8'hFF);
		u_c.lines(1'b0, 1'b1);
		idle(3);
		rdx(3'h1, 8'h00, 8'hFF);
		rdx(3'h1, 8'h00, 8'hFF);
		u_c.lines(1'b1, 1'b0);
		idle(1);
		u_c.rx;
		rdx(3'h1, 8'h48, 8'hFF);
		bus(1'b1, 1'b0, 3'h3, 8'h04);
		idle(2);
		rdx(3'h1, 8'h08, 8'hFF);
		pulse(7'h11);
		rdx(3'h1, 8'h20, 8'hFF);
		u_c.cmd(1'b1, {r, 7'h14});
		rdx(3'h1, 8'h22, 8'hFF);
		pin(2'b01);
		rdx(3'h0, 8'h04, 8'h04);
		u_c.cmd(1'b0, 8'h00);
		idle(1);
		rdx(3'h1, 8'h20, 8'hFF);
		for (i = 0; i < 2; i = i + 1) begin
			u_c.lines(1'b1, i[0]);
			u_c.cmd(1'b1, {r, 7'h04});
			rdx(3'h1, i ? 8'h22 : 8'h20, 8'hFF);
		end
		u_c.lines(1'b1, 1'b0);
		idle(1);
		rdx(3'h1, 8'h20, 8'hFF);
		u_c.cmd(1'b0, 8'h00);
		u_c.lines(1'b1, 1'b1);
		pulse(7'h08);
		pin(2'b11);
		bus(1'b1, 1'b0, 3'h3, 8'h10);
		idle(2);
		pin(2'b00);
		rdx(3'h3, 8'h00, 8'h10);
		rdx(3'h0, 8'h20, 8'h20);
		rdx(3'h0, 8'h00, 8'h20);
		bus(1'b1, 1'b0, 3'h2, 8'h80);
		idle(1);
		pulse(7'h08);
		pin(2'b00);
		rdx(3'h0, 8'h00, 8'h20);
		bus(1'b1, 1'b0, 3'h3, 8'h01);
		idle(1);
		pin(2'b10);
		rdx(3'h0, 8'h00, 8'h20);
		bus(1'b1, 1'b0, 3'h3, 8'h00);
		idle(2);
		pin(2'b00);
		idle(2);
		test_done;
	end
endmodule // test_remote_clear_trigger_functions
bind rct_top rct_chk_monitor u_mon (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .REN(REN), .CMD_VALID(CMD_VALID),
	.CMD_CODE(CMD_CODE), .LISTEN_ADDR_RX(LISTEN_ADDR_RX), .LISTEN_ADDRESSED(LISTEN_ADDRESSED),
	.DAC_HOLD(DAC_HOLD), .TRIGGER_OUT(TRIGGER_OUT));
